// [verilog/popv_pkg.sv]
// package of shared constants and types for the pulse output block
// assumes a single 25 MHz system clock and an AXI4-Lite register bus
package popv_pkg;

  // timing
  localparam int CLK_HZ = 25000000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int CMD_SETTLE_NS = 200;
  localparam int CMD_SETTLE_CYCLES = (CMD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_OUTSEL = 8'h04;
  localparam logic [7:0] OFF_FREQ = 8'h08;
  localparam logic [7:0] OFF_DUTY = 8'h0C;
  localparam logic [7:0] OFF_TARGET = 8'h10;
  localparam logic [7:0] OFF_FUNC = 8'h14;
  localparam logic [7:0] OFF_STEPS = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_ERRCODE = 8'h20;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
  localparam logic [7:0] OFF_ENABLE = 8'h2C;

  // field positions
  localparam int CTRL_POS_BIT = 0;
  localparam int CTRL_VEL_BIT = 1;
  localparam int STAT_SUCCESS_BIT = 0;
  localparam int STAT_ERROR_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_RUN_LSB = 4;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam int EN_OUT_LSB = 0;
  localparam int EN_DIR_LSB = 4;
  localparam int FUNC_GT_BIT = 4;

  // reset values
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESET_IRQ_MASK = 2'h0;

  // parameter limits
  localparam logic [31:0] FREQ_MIN_HZ = 32'h0000_0014;
  localparam logic [31:0] DUTY_MAX = 32'h0000_0063;
  localparam logic [31:0] DUTY_DEFAULT = 32'h0000_0032;
  localparam logic [31:0] TARGET_MAX = 32'h7FFF_4020;
  localparam logic [31:0] STEPS_CONTINUOUS = 32'hFFFF_FFFF;
  localparam logic [31:0] OUTSEL_MAX = 32'h0000_0003;
  localparam logic [3:0] FUNC_HI_MAX = 4'h1;
  localparam logic [3:0] FUNC_LO_MAX = 4'h3;

  // extended error codes
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_UNKNOWN_CMD = 16'h0064;
  localparam logic [15:0] ERR_FUNC_INVALID = 16'h006A;
  localparam logic [15:0] ERR_FUNC_RANGE = 16'h006B;
  localparam logic [15:0] ERR_REG_RANGE = 16'h006F;

  typedef enum logic {MODE_POSITION, MODE_VELOCITY} popv_mode_type;

  typedef struct packed {
    popv_mode_type mode;
    logic [17:0] freqHz;
    logic [24:0] thresh;
    logic [31:0] steps;
    logic [31:0] target;
    logic [7:0] func;
  } popv_cfg_type;

endpackage

// [verilog/popv_pulse_gen.sv]
// one pulse output resource: phase accumulator step generator
// assumes cfgIn is stable in the cycle that load is high
`timescale 1ns/10ps
module popv_pulse_gen
#(
  parameter int CLK_HZ = popv_pkg::CLK_HZ
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstSync_n,
  // command load
  input wire logic load,
  input popv_pkg::popv_cfg_type cfgIn,
  input wire logic enable,
  // encoder counts, two channels by two functions
  input wire logic [3:0][31:0] encCount,
  // outputs
  output logic stepOut,
  output logic running
);

  // the phase accumulator is 25 bits wide
  if (CLK_HZ < 100 || CLK_HZ > 33554431)
    $error("CLK_HZ outside what the phase accumulator holds");

  localparam logic [25:0] CLK_CNT = 26'(CLK_HZ);

  popv_pkg::popv_cfg_type cfgReg;
  logic activeReg;
  logic [24:0] accReg;
  logic [31:0] countReg;
  logic stepReg;
  logic [25:0] accSum;
  logic wrap;
  logic [31:0] cmpCnt;
  logic hit;
  logic stopNow;
  logic isCont;

  assign accSum = {1'b0, accReg} + {8'h00, cfgReg.freqHz};
  assign wrap = accSum >= CLK_CNT;
  assign isCont = cfgReg.steps == popv_pkg::STEPS_CONTINUOUS;
  assign cmpCnt = encCount[cfgReg.func[1:0]];
  // upper digit picks greater-than, lower digit picks channel/function
  assign hit = cfgReg.func[popv_pkg::FUNC_GT_BIT] ? (cmpCnt > cfgReg.target)
                                                  : (cmpCnt < cfgReg.target); // RULE_02
  always_comb
  begin
    if (cfgReg.mode == popv_pkg::MODE_POSITION)
      stopNow = hit; // RULE_07
    else
      stopNow = !isCont && enable && wrap && (countReg + 32'h1 >= cfgReg.steps); // RULE_11
  end

  always_ff @(posedge clk_sys or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      cfgReg <= '0;
      activeReg <= 1'b0;
      accReg <= '0;
      countReg <= '0;
    end
    else if (load)
    begin
      cfgReg <= cfgIn;
      // a zero step count in velocity mode has nothing to emit
      activeReg <= !(cfgIn.mode == popv_pkg::MODE_VELOCITY && cfgIn.steps == '0);
      accReg <= '0;
      countReg <= '0;
    end
    else if (activeReg)
    begin
      if (stopNow)
        activeReg <= 1'b0;
      // output pauses while disabled but keeps its phase and count
      if (enable)
      begin
        accReg <= wrap ? 25'(accSum - CLK_CNT) : accSum[24:0];
        if (wrap)
          countReg <= countReg + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_n)
  begin
    if (!rstSync_n)
      stepReg <= 1'b0;
    else
      stepReg <= activeReg && enable && !stopNow && (accReg < cfgReg.thresh); // RULE_06
  end

  assign stepOut = stepReg;
  assign running = activeReg;

endmodule // popv_pulse_gen

// [verilog/popv_top.sv]
// pulse output command block: position and velocity commands over AXI4-Lite
// assumes encoder counts arrive synchronous to clk_sys, one word per channel/function
//
// Overview of operation
// RULE_01: position request edge latches command and parameters
// RULE_02: selector digits choose compare sense and source
// RULE_03: command ends with exactly success or error
// RULE_04: error leaves a readable extended error code
// RULE_05: frequency in hertz, twenty up to maximum
// RULE_06: duty percent, zero means fifty percent
// RULE_07: position mode stops when comparison is satisfied
// RULE_08: output selector picks one of four outputs
// RULE_09: controller addresses module by its number
// RULE_10: velocity request edge latches command and parameters
// RULE_11: step count, all ones runs continuously
// RULE_12: negative step counts come from memory words
// RULE_13: controller keeps each workspace word private
// RULE_14: controller sets direction, then enables output
// RULE_15: module configured before any pulse command
// RULE_16: error code zero, hundred, kept until next
// RULE_17: new request edge clears success and error
`timescale 1ns/10ps
module popv_top
#(
  parameter int MAX_FREQ_HZ = 20000,
  parameter int NUM_OUTPUTS = 4
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // encoder inputs
  input wire logic [3:0][31:0] encCount,
  // motor drive
  output logic [3:0] stepOut,
  output logic [3:0] dirOut,
  // interrupt
  output logic irq
);

  if (MAX_FREQ_HZ < 20 || MAX_FREQ_HZ > 250000)
    $error("MAX_FREQ_HZ outside 20 to 250000");
  if (NUM_OUTPUTS != 4)
    $error("NUM_OUTPUTS must be 4");
  if (popv_pkg::CLK_HZ % 100 != 0)
    $error("clock rate must be a multiple of 100 Hz");

  localparam logic [31:0] FREQ_MAX = 32'(MAX_FREQ_HZ);
  localparam logic [24:0] THRESH_PER_PCT = 25'(popv_pkg::CLK_HZ / 100);
  localparam logic [3:0] SETTLE_LAST = 4'(popv_pkg::CMD_SETTLE_CYCLES - 1);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_REPORT} popv_state_type;

  // reset release through two flip-flops
  logic rstMeta_n;
  logic rstSync_n;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end
    else
    begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[8*i +: 8] = nw[8*i +: 8];
    return res;
  endfunction

  // write channel capture; address and data taken in either order
  logic [7:0] awAddrReg;
  logic awHeldReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;
  logic wHeldReg;
  logic bValidReg;
  logic [1:0] bRespReg;
  logic doWrite;
  logic wrMapped;

  assign s_axi_awready = !awHeldReg && !bValidReg;
  assign s_axi_wready = !wHeldReg && !bValidReg;
  assign doWrite = awHeldReg && wHeldReg && !bValidReg;
  assign s_axi_bvalid = bValidReg;
  assign s_axi_bresp = bRespReg;
  assign wrMapped = awAddrReg[1:0] == 2'h0 && awAddrReg <= popv_pkg::OFF_ENABLE
                    && awAddrReg != popv_pkg::OFF_STATUS && awAddrReg != popv_pkg::OFF_ERRCODE;

  always_ff @(posedge clk_sys or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      awAddrReg <= '0;
      awHeldReg <= 1'b0;
      wDataReg <= '0;
      wStrbReg <= '0;
      wHeldReg <= 1'b0;
      bValidReg <= 1'b0;
      bRespReg <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddrReg <= s_axi_awaddr;
        awHeldReg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
        wHeldReg <= 1'b1;
      end
      if (doWrite)
      begin
        awHeldReg <= 1'b0;
        wHeldReg <= 1'b0;
        bValidReg <= 1'b1;
        bRespReg <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bValidReg && s_axi_bready)
        bValidReg <= 1'b0;
    end
  end

  // software registers
  logic [1:0] ctrlReg;
  logic [31:0] outSelReg;
  logic [31:0] freqReg;
  logic [31:0] dutyReg;
  logic [31:0] targetReg;
  logic [31:0] funcReg;
  logic [31:0] stepsReg;
  logic [1:0] irqMaskReg;
  logic [7:0] enableReg;

  always_ff @(posedge clk_sys or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      ctrlReg <= '0;
      outSelReg <= popv_pkg::RESET_ZERO;
      freqReg <= popv_pkg::RESET_ZERO;
      dutyReg <= popv_pkg::RESET_ZERO;
      targetReg <= popv_pkg::RESET_ZERO;
      funcReg <= popv_pkg::RESET_ZERO;
      stepsReg <= popv_pkg::RESET_ZERO;
      irqMaskReg <= popv_pkg::RESET_IRQ_MASK;
      enableReg <= '0;
    end
    else if (doWrite)
    begin
      case (awAddrReg)
        popv_pkg::OFF_CTRL: if (wStrbReg[0]) ctrlReg <= wDataReg[1:0];
        popv_pkg::OFF_OUTSEL: outSelReg <= mergeBytes(outSelReg, wDataReg, wStrbReg);
        popv_pkg::OFF_FREQ: freqReg <= mergeBytes(freqReg, wDataReg, wStrbReg);
        popv_pkg::OFF_DUTY: dutyReg <= mergeBytes(dutyReg, wDataReg, wStrbReg);
        popv_pkg::OFF_TARGET: targetReg <= mergeBytes(targetReg, wDataReg, wStrbReg);
        popv_pkg::OFF_FUNC: funcReg <= mergeBytes(funcReg, wDataReg, wStrbReg);
        popv_pkg::OFF_STEPS: stepsReg <= mergeBytes(stepsReg, wDataReg, wStrbReg);
        popv_pkg::OFF_IRQ_MASK: if (wStrbReg[0]) irqMaskReg <= wDataReg[1:0];
        popv_pkg::OFF_ENABLE: if (wStrbReg[0]) enableReg <= wDataReg[7:0];
        default: ;
      endcase
    end
  end

  // request edges
  logic [1:0] ctrlPrevReg;
  logic posEdge;
  logic velEdge;
  always_ff @(posedge clk_sys or negedge rstSync_n)
  begin
    if (!rstSync_n)
      ctrlPrevReg <= '0;
    else
      ctrlPrevReg <= ctrlReg;
  end
  assign posEdge = ctrlReg[popv_pkg::CTRL_POS_BIT] && !ctrlPrevReg[popv_pkg::CTRL_POS_BIT];
  assign velEdge = ctrlReg[popv_pkg::CTRL_VEL_BIT] && !ctrlPrevReg[popv_pkg::CTRL_VEL_BIT];

  // command sequencer
  popv_state_type stateReg;
  logic [3:0] settleReg;
  popv_pkg::popv_cfg_type cmdReg;
  logic [1:0] cmdOutReg;
  logic [15:0] pendErrReg;
  logic successReg;
  logic errorReg;
  logic [15:0] errCodeReg;
  logic [3:0] loadVec;
  logic doneEvt;
  logic errEvt;
  logic [15:0] checkErr;
  logic [31:0] dutyEff;

  // zero duty is the same as fifty percent
  assign dutyEff = (dutyReg == '0) ? popv_pkg::DUTY_DEFAULT : dutyReg; // RULE_06

  always_comb
  begin
    checkErr = popv_pkg::ERR_NONE;
    if (posEdge && velEdge)
      checkErr = popv_pkg::ERR_UNKNOWN_CMD; // RULE_16
    else if (outSelReg > popv_pkg::OUTSEL_MAX) // RULE_08
      checkErr = popv_pkg::ERR_REG_RANGE;
    else if (freqReg < popv_pkg::FREQ_MIN_HZ || freqReg > FREQ_MAX) // RULE_05
      checkErr = popv_pkg::ERR_REG_RANGE;
    else if (dutyReg > popv_pkg::DUTY_MAX)
      checkErr = popv_pkg::ERR_REG_RANGE;
    else if (posEdge && (funcReg[31:8] != '0 || funcReg[7:4] > popv_pkg::FUNC_HI_MAX))
      checkErr = popv_pkg::ERR_FUNC_INVALID; // RULE_02
    else if (posEdge && funcReg[3:0] > popv_pkg::FUNC_LO_MAX)
      checkErr = popv_pkg::ERR_FUNC_RANGE;
    else if (posEdge && targetReg > popv_pkg::TARGET_MAX) // RULE_07
      checkErr = popv_pkg::ERR_REG_RANGE;
  end

  always_ff @(posedge clk_sys or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      stateReg <= ST_IDLE;
      settleReg <= '0;
      cmdReg <= '0;
      cmdOutReg <= '0;
      pendErrReg <= popv_pkg::ERR_NONE;
    end
    else
    begin
      case (stateReg)
        ST_IDLE:
          if (posEdge || velEdge) // RULE_01 RULE_10
          begin
            cmdReg.mode <= posEdge ? popv_pkg::MODE_POSITION : popv_pkg::MODE_VELOCITY;
            cmdReg.freqHz <= freqReg[17:0];
            cmdReg.thresh <= 25'(THRESH_PER_PCT * dutyEff[6:0]);
            cmdReg.steps <= stepsReg; // RULE_11
            cmdReg.target <= targetReg;
            cmdReg.func <= funcReg[7:0];
            cmdOutReg <= outSelReg[1:0];
            pendErrReg <= checkErr;
            settleReg <= '0;
            stateReg <= ST_SETTLE;
          end
        ST_SETTLE:
          // the command takes several cycles, as a scan-based controller expects
          if (settleReg == SETTLE_LAST)
            stateReg <= ST_REPORT; // RULE_03
          else
            settleReg <= settleReg + 4'h1;
        ST_REPORT:
          stateReg <= ST_IDLE;
        default:
          stateReg <= ST_IDLE;
      endcase
    end
  end

  assign doneEvt = stateReg == ST_REPORT;
  assign errEvt = doneEvt && pendErrReg != popv_pkg::ERR_NONE;
  assign loadVec = (doneEvt && !errEvt) ? (4'h1 << cmdOutReg) : 4'h0; // RULE_08

  // outcome flags and error code
  always_ff @(posedge clk_sys or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      successReg <= 1'b0;
      errorReg <= 1'b0;
      errCodeReg <= popv_pkg::ERR_NONE;
    end
    else if (stateReg == ST_IDLE && (posEdge || velEdge))
    begin
      successReg <= 1'b0; // RULE_17
      errorReg <= 1'b0;
      errCodeReg <= popv_pkg::ERR_NONE; // RULE_16
    end
    else if (doneEvt)
    begin
      successReg <= !errEvt; // RULE_03
      errorReg <= errEvt;
      errCodeReg <= pendErrReg; // RULE_04
    end
  end

  // sticky interrupt status, write one to clear, a new event wins
  logic [1:0] irqStatReg;
  logic [1:0] irqSet;
  logic [1:0] irqClr;
  assign irqSet = {errEvt, doneEvt};
  assign irqClr = (doWrite && awAddrReg == popv_pkg::OFF_IRQ_STAT && wStrbReg[0])
                  ? wDataReg[1:0] : 2'h0;
  always_ff @(posedge clk_sys or negedge rstSync_n)
  begin
    if (!rstSync_n)
      irqStatReg <= '0;
    else
      irqStatReg <= (irqStatReg & ~irqClr) | irqSet;
  end
  assign irq = |(irqStatReg & irqMaskReg);

  // pulse output resources
  logic [3:0] runVec;
  for (genvar g = 0; g < NUM_OUTPUTS; g++)
  begin : gen_out
    popv_pulse_gen #(.CLK_HZ(popv_pkg::CLK_HZ)) u_gen (
      .clk_sys(clk_sys),
      .rstSync_n(rstSync_n),
      .load(loadVec[g]),
      .cfgIn(cmdReg),
      .enable(enableReg[popv_pkg::EN_OUT_LSB + g]),
      .encCount(encCount),
      .stepOut(stepOut[g]),
      .running(runVec[g])
    );
  end

  // direction is software owned; it is set before enabling the output
  always_ff @(posedge clk_sys or negedge rstSync_n)
  begin
    if (!rstSync_n)
      dirOut <= '0;
    else
      dirOut <= enableReg[popv_pkg::EN_DIR_LSB +: 4];
  end

  // read channel
  logic rValidReg;
  logic [31:0] rDataReg;
  logic [1:0] rRespReg;
  logic [31:0] rdMux;
  logic rdMapped;
  assign s_axi_arready = !rValidReg;
  assign s_axi_rvalid = rValidReg;
  assign s_axi_rdata = rDataReg;
  assign s_axi_rresp = rRespReg;

  always_comb
  begin
    rdMux = '0;
    rdMapped = 1'b1;
    case (s_axi_araddr)
      popv_pkg::OFF_CTRL: rdMux = {30'h0, ctrlReg};
      popv_pkg::OFF_OUTSEL: rdMux = outSelReg;
      popv_pkg::OFF_FREQ: rdMux = freqReg;
      popv_pkg::OFF_DUTY: rdMux = dutyReg;
      popv_pkg::OFF_TARGET: rdMux = targetReg;
      popv_pkg::OFF_FUNC: rdMux = funcReg;
      popv_pkg::OFF_STEPS: rdMux = stepsReg;
      popv_pkg::OFF_STATUS: rdMux = {24'h0, runVec, 1'b0, stateReg != ST_IDLE,
                                     errorReg, successReg};
      popv_pkg::OFF_ERRCODE: rdMux = {16'h0, errCodeReg}; // RULE_04
      popv_pkg::OFF_IRQ_STAT: rdMux = {30'h0, irqStatReg};
      popv_pkg::OFF_IRQ_MASK: rdMux = {30'h0, irqMaskReg};
      popv_pkg::OFF_ENABLE: rdMux = {24'h0, enableReg};
      default: rdMapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      rValidReg <= 1'b0;
      rDataReg <= '0;
      rRespReg <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rValidReg <= 1'b1;
      rDataReg <= rdMux;
      rRespReg <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rValidReg && s_axi_rready)
      rValidReg <= 1'b0;
  end

endmodule // popv_top

// [testbench/popv_properties.sv]
// checker for the pulse output block: bus handshakes and step rate at the top ports
// assumes one clk_sys domain and is bound into popv_top below
`timescale 1ns/10ps
module popv_props
#(
  parameter int MAX_FREQ_HZ = 20000
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // motor drive
  input wire logic [3:0] stepOut
);
  // one cycle of slack: accumulator wrap may land a cycle apart
  localparam int MIN_GAP = popv_pkg::CLK_HZ / MAX_FREQ_HZ - 2;
  logic [3:0][31:0] sinceRise;
  logic [3:0] stepLast;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence writeTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence readTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sinceRise <= '1;
      stepLast <= 4'h0;
    end
    else
    begin
      stepLast <= stepOut;
      for (int i = 0; i < 4; i++)
      begin
        if (stepOut[i] && !stepLast[i]) sinceRise[i] <= 32'h0;
        else if (sinceRise[i] != 32'hFFFFFFFF) sinceRise[i] <= sinceRise[i] + 32'h1;
      end
    end
  end
  AST_WRITE_ANSWER: assert property (writeTaken |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  AST_READ_ANSWER: assert property (readTaken |-> ##[1:2] s_axi_rvalid)
    else $error("read data missing");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  AST_NO_WRITE_WHILE_B: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_NO_READ_WHILE_R: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  AST_RESP_CODES: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2})
    else $error("read response code illegal");
  for (genvar g = 0; g < 4; g++)
  begin : gStep
    AST_STEP_RATE: assert property ($rose(stepOut[g]) |-> sinceRise[g] >= MIN_GAP)
      else $error("step rate above maximum frequency");
  end
endmodule // popv_props

bind popv_top popv_props #(.MAX_FREQ_HZ(MAX_FREQ_HZ)) uProps (.clk_sys(clk_sys), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .stepOut(stepOut));

// [testbench/popv_encoder_model.sv]
// motor and encoder model: each step edge moves the matching encoder word
// assumes direction high counts up; encoder words follow one cycle after the step
`timescale 1ns/10ps
module popv_encoder_model
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // motor drive
  input wire logic [3:0] stepOut,
  input wire logic [3:0] dirOut,
  // encoder feedback
  output logic [3:0][31:0] encCount
);
  logic [3:0] stepLast;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stepLast <= 4'h0;
      encCount <= '0;
    end
    else
    begin
      stepLast <= stepOut;
      for (int i = 0; i < 4; i++)
      begin
        if (stepOut[i] && !stepLast[i])
        begin
          encCount[i] <= dirOut[i] ? encCount[i] + 32'h1 : encCount[i] - 32'h1;
        end
      end
    end
  end
endmodule // popv_encoder_model

// [testbench/testbench.sv]
// self-checking bench: bus master, command sequences and step counting
// assumes popv_top, the encoder model and the bound checker are compiled first
`timescale 1ns/10ps
module testbench;
  logic clk_sys, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0][31:0] encCount;
  logic [3:0] stepOut, dirOut;
  int fails, n_compared;
  popv_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .encCount(encCount), .stepOut(stepOut), .dirOut(dirOut), .irq(irq));
  popv_encoder_model motor (.clk_sys(clk_sys), .rst_n(rst_n), .stepOut(stepOut),
    .dirOut(dirOut), .encCount(encCount));
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic summarize;
    if (fails == 0 && n_compared > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    @(posedge clk_sys);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    r = 2'h3;
    while (r === 2'h3)
    begin
      @(posedge clk_sys);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
      end
    end
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    {araddr, arvalid, rready} <= {a, 2'b11};
    r = 2'h3;
    while (r === 2'h3)
    begin
      @(posedge clk_sys);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic params(input logic [31:0] sel, fr, du, tg, fn, st);
    wrc(8'h04, sel, 2'h0);
    wrc(8'h08, fr, 2'h0);
    wrc(8'h0C, du, 2'h0);
    wrc(8'h10, tg, 2'h0);
    wrc(8'h14, fn, 2'h0);
    wrc(8'h18, st, 2'h0);
  endtask
  // request edge, wait for the outcome, then drop the request bit again
  task automatic cmd(input logic [31:0] bits, input logic [31:0] expSt, input logic [31:0] expErr);
    logic [31:0] st;
    logic [1:0] r;
    int n;
    wrc(8'h00, bits, 2'h0);
    repeat (2) @(posedge clk_sys);
    st = 32'h4;
    n = 0;
    while ((st[2] || st[1:0] == 2'h0) && n < 40)
    begin
      rd(8'h1C, st, r);
      if (st[2]) chk({30'h0, st[1:0]}, 32'h0);
      n++;
    end
    chk({29'h0, st[2:0]}, expSt);
    rdc(8'h20, expErr, 2'h0);
    wrc(8'h00, 32'h0, 2'h0);
  endtask
  task automatic pulses(input int ch, input int cyc, output int rises, output int high);
    logic last;
    last = 1'b0;
    rises = 0;
    high = 0;
    repeat (cyc)
    begin
      @(posedge clk_sys);
      if (stepOut[ch] && !last) rises++;
      if (stepOut[ch]) high++;
      last = stepOut[ch];
    end
  endtask
  task automatic t_regs;
    rdc(8'h1C, 32'h0, 2'h0);
    rdc(8'h20, 32'h0, 2'h0);
    rdc(8'h28, 32'h0, 2'h0);
    rdc(8'h40, 32'h0, 2'h2);
    wrc(8'h1C, 32'h3, 2'h2);
    rdc(8'h1C, 32'h0, 2'h0);
  endtask
  task automatic t_errors;
    logic [7:0] badAddr [7] = '{8'h04, 8'h08, 8'h08, 8'h0C, 8'h14, 8'h14, 8'h10};
    logic [31:0] badVal [7] = '{32'h4, 32'h13, 32'h4E21, 32'h64, 32'h20, 32'h4, 32'h7FFF4021};
    logic [31:0] badCode [7] = '{32'h6F, 32'h6F, 32'h6F, 32'h6F, 32'h6A, 32'h6B, 32'h6F};
    for (int i = 0; i < 7; i++)
    begin
      params(32'h3, 32'h14, 32'h63, 32'h7FFF4020, 32'h13, 32'h0);
      wrc(badAddr[i], badVal[i], 2'h0);
      cmd(32'h1, 32'h2, badCode[i]);
    end
    cmd(32'h3, 32'h2, 32'h64);
    rdc(8'h24, 32'h3, 2'h0);
    chk({31'h0, irq}, 32'h0);
    wrc(8'h28, 32'h2, 2'h0);
    chk({31'h0, irq}, 32'h1);
    wrc(8'h24, 32'h2, 2'h0);
    chk({31'h0, irq}, 32'h0);
    rdc(8'h24, 32'h1, 2'h0);
    wrc(8'h24, 32'h1, 2'h0);
    rdc(8'h24, 32'h0, 2'h0);
    cmd(32'h2, 32'h1, 32'h0);
  endtask
  task automatic t_velocity(input int ch, input logic [31:0] du, input logic [31:0] st);
    int rises, high;
    params(ch, 32'h4E20, du, 32'h0, 32'h0, st);
    cmd(32'h2, 32'h1, 32'h0);
    wrc(8'h2C, 32'h10 << ch, 2'h0);
    wrc(8'h2C, 32'h11 << ch, 2'h0);
    pulses(ch, 6000, rises, high);
    chk({31'h0, dirOut[ch]}, 32'h1);
    wrc(8'h2C, 32'h0, 2'h0);
    if (st == 32'hFFFFFFFF) chk(32'(rises >= 4 && rises <= 5), 32'h1);
    else chk(32'(rises), st);
    if (du == 32'h0) chk(32'(high >= 1872 && high <= 1878), 32'h1);
  endtask
  task automatic t_position(input logic [31:0] fn, input logic [31:0] en, input int nExp);
    int rises, high;
    params(32'h0, 32'h4E20, 32'h32, 32'h2, fn, 32'h0);
    cmd(32'h1, 32'h1, 32'h0);
    wrc(8'h2C, en, 2'h0);
    pulses(0, 8000, rises, high);
    wrc(8'h2C, 32'h0, 2'h0);
    chk(32'(rises), nExp);
    chk(encCount[0], (fn == 32'h10) ? 32'h3 : 32'h1);
  endtask
  initial
  begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    fails = 0;
    n_compared = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs;
    t_errors;
    t_velocity(1, 32'h0, 32'h3);
    t_velocity(2, 32'h63, 32'hFFFFFFFF);
    t_position(32'h10, 32'h11, 3);
    t_position(32'h00, 32'h01, 2);
    summarize;
  end
  // roughly twice the expected run length
  initial
  begin
    #2400000;
    fails++;
    summarize;
  end
endmodule // testbench
